//--- pkg/dlct_pkg.sv
// package for the dual legacy counter/timer block
// assumes a single system clock; all control bits arrive as plain ports
package dlct_pkg;
	// ------------------------------------------------------------
	// modes of each timer
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DLCT_MODE13 = 2'b00,
		DLCT_MODE16 = 2'b01,
		DLCT_MODE8R = 2'b10,
		DLCT_MODESPLIT = 2'b11
	} dlct_mode_t;

	// ------------------------------------------------------------
	// prescale field encodings and divide counts
	// ------------------------------------------------------------
	localparam logic [1:0] DLCT_PS_DIV12 = 2'h0;
	localparam logic [1:0] DLCT_PS_DIV4 = 2'h1;
	localparam logic [1:0] DLCT_PS_DIV48 = 2'h2;
	localparam logic [1:0] DLCT_PS_EXT8 = 2'h3;
	localparam logic [5:0] DLCT_DIV12 = 6'h0C;
	localparam logic [5:0] DLCT_DIV4 = 6'h04;
	localparam logic [5:0] DLCT_DIV48 = 6'h30;
	localparam logic [5:0] DLCT_DIV8 = 6'h08;

	// ------------------------------------------------------------
	// reset values and 13-bit count maximum
	// ------------------------------------------------------------
	localparam logic [7:0] DLCT_COUNT_RST = 8'h00;
	localparam logic [5:0] DLCT_PS_RST = 6'h00;
	localparam logic [12:0] DLCT_MAX13 = 13'h1FFF;
endpackage : dlct_pkg

//--- logic/dlct_timers.sv
// two legacy counter/timers with shared prescaler and gating
// assumes pins synchronous to clk; software sees bytes via write ports
//
// Operation
// - 16-bit count as low and high bytes
// - shared prescaler: sysclk/12, /4, /48, ext/8
// - clock select: sysclk or prescaled timebase
// - counter mode counts falling event pin edges, except timer 1 while timer 0 is split
// - two-bit mode field per timer, independent
// - mode 0 is 13-bit, low bits 4:0
// - 13-bit wrap sets flag, interrupt if enabled
// - interrupt forwarded only when enable set
// - count when run and gate allows; timer 1 ignores both while timer 0 is split
// - polarity bit picks active gate level
// - timer 1 mirrors timer 0 modes 0-2
// - overflow pulses exported to peripherals
// - mode 1 counts full 16 bits
// - mode 2 reloads low byte from high
// - mode 3 splits timer 0 in two
// - timer 1 mode 3 halts; its flag then set only by timer 0 high half overflow
`timescale 1ns/10ps
module dlct_timers (
	input wire logic clk,
	input wire logic resetn,
	input wire dlct_pkg::dlct_mode_t t0Mode,
	input wire dlct_pkg::dlct_mode_t t1Mode,
	input wire logic [1:0] prescaleField,
	input wire logic t0ClockSelect,
	input wire logic t1ClockSelect,
	input wire logic t0CounterMode,
	input wire logic t1CounterMode,
	input wire logic t0Run,
	input wire logic t1Run,
	input wire logic t0GateEnable,
	input wire logic t1GateEnable,
	input wire logic t0GatePolarity,
	input wire logic t1GatePolarity,
	input wire logic t0IrqEnable,
	input wire logic t1IrqEnable,
	input wire logic extClock,
	input wire logic t0EventPin,
	input wire logic t1EventPin,
	input wire logic t0GateInput,
	input wire logic t1GateInput,
	input wire logic t0LowWrite,
	input wire logic t0HighWrite,
	input wire logic t1LowWrite,
	input wire logic t1HighWrite,
	input wire logic [7:0] writeData,
	input wire logic t0FlagClear,
	input wire logic t1FlagClear,
	input wire logic t0IrqAck,
	input wire logic t1IrqAck,
	output logic [7:0] t0CountLow,
	output logic [7:0] t0CountHigh,
	output logic [7:0] t1CountLow,
	output logic [7:0] t1CountHigh,
	output logic t0OverflowFlag,
	output logic t1OverflowFlag,
	output logic t0Irq,
	output logic t1Irq,
	output logic t0OverflowPulse,
	output logic t1OverflowPulse
);
	import dlct_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] evt0Sync_reg, evt1Sync_reg, gate0Sync_reg, gate1Sync_reg;
	logic [1:0] extSync_reg;
	logic evt0Prev_reg, evt1Prev_reg, extPrev_reg;
	logic evt0Fall, evt1Fall, extFall;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			evt0Sync_reg <= 2'h0;
			evt1Sync_reg <= 2'h0;
			gate0Sync_reg <= 2'h0;
			gate1Sync_reg <= 2'h0;
			extSync_reg <= 2'h0;
			evt0Prev_reg <= 1'b0;
			evt1Prev_reg <= 1'b0;
			extPrev_reg <= 1'b0;
		end else begin
			evt0Sync_reg <= {evt0Sync_reg[0], t0EventPin};
			evt1Sync_reg <= {evt1Sync_reg[0], t1EventPin};
			gate0Sync_reg <= {gate0Sync_reg[0], t0GateInput};
			gate1Sync_reg <= {gate1Sync_reg[0], t1GateInput};
			extSync_reg <= {extSync_reg[0], extClock};
			evt0Prev_reg <= evt0Sync_reg[1];
			evt1Prev_reg <= evt1Sync_reg[1];
			extPrev_reg <= extSync_reg[1];
		end
	end

	// slow pins assumed, so no edge is missed
	assign evt0Fall = evt0Prev_reg & ~evt0Sync_reg[1];
	assign evt1Fall = evt1Prev_reg & ~evt1Sync_reg[1];
	assign extFall = extPrev_reg & ~extSync_reg[1];

	// ------------------------------------------------------------
	// shared prescaler
	// ------------------------------------------------------------
	logic [5:0] psCount_reg;
	logic [5:0] psDivide;
	logic psTick;
	logic psStep;

	// divide value from the prescale field
	always_comb begin
		case (prescaleField)
			DLCT_PS_DIV12: psDivide = DLCT_DIV12;
			DLCT_PS_DIV4: psDivide = DLCT_DIV4;
			DLCT_PS_DIV48: psDivide = DLCT_DIV48;
			default: psDivide = DLCT_DIV8;
		endcase
	end
	// external source advances only on its own falling edges
	assign psStep = (prescaleField == DLCT_PS_EXT8) ? extFall : 1'b1;
	assign psTick = psStep && (psCount_reg >= psDivide - 6'h01);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			psCount_reg <= DLCT_PS_RST;
		end else if (psTick) begin
			psCount_reg <= DLCT_PS_RST;
		end else if (psStep) begin
			psCount_reg <= psCount_reg + 6'h01;
		end
	end

	// ------------------------------------------------------------
	// count enables
	// ------------------------------------------------------------
	logic split;
	logic t0Gate, t1Gate, t0Step, t1Step, t0hStep;
	logic t0Internal, t1Internal;

	assign split = (t0Mode == DLCT_MODESPLIT);
	assign t0Internal = t0ClockSelect | psTick;
	assign t1Internal = t1ClockSelect | psTick;
	assign t0Gate = t0Run &
		(~t0GateEnable | (gate0Sync_reg[1] == t0GatePolarity));
	// in split mode timer 1 runs by mode alone
	assign t1Gate = split ? 1'b1 : (t1Run &
		(~t1GateEnable | (gate1Sync_reg[1] == t1GatePolarity)));
	assign t0Step = t0Gate & (t0CounterMode ? evt0Fall : t0Internal);
	assign t1Step = t1Gate & (t1Mode != DLCT_MODESPLIT) &
		((t1CounterMode & ~split) ? evt1Fall : t1Internal);
	// high half uses internal clock and timer 1 run
	assign t0hStep = split & t1Run & t0Internal;

	// ------------------------------------------------------------
	// counting function shared by both timers
	// ------------------------------------------------------------
	// each timer's own mode; returns {ovf, high, low}
	function automatic logic [16:0] dlct_step(input dlct_mode_t mode,
			input logic [7:0] lo, input logic [7:0] hi);
		logic [12:0] c13;
		logic [16:0] c16;
		logic [8:0] c8;
		c13 = 13'h0000;
		c16 = 17'h00000;
		c8 = 9'h000;
		case (mode)
			// 13 bits from high byte and low 4:0
			DLCT_MODE13: begin
				c13 = {hi, lo[4:0]} + 13'h0001;
				// wrap from all ones to zero
				dlct_step = {({hi, lo[4:0]} == DLCT_MAX13), c13[12:5],
					lo[7:5], c13[4:0]};
			end
			DLCT_MODE16: begin
				c16 = {1'b0, hi, lo} + 17'h00001;
				dlct_step = c16;
			end
			// reload low from high on wrap
			DLCT_MODE8R: begin
				c8 = {1'b0, lo} + 9'h001;
				dlct_step = {c8[8], hi, c8[8] ? hi : c8[7:0]};
			end
			// low-byte-only 8-bit count, used for the split case
			default: begin
				c8 = {1'b0, lo} + 9'h001;
				dlct_step = {c8[8], hi, c8[7:0]};
			end
		endcase
	endfunction : dlct_step

	logic [16:0] t0Next, t1Next;
	logic [8:0] t0hNext;
	logic t0Ovf, t1Ovf, t0hOvf;

	assign t0Next = dlct_step(t0Mode, t0CountLow, t0CountHigh);
	assign t1Next = dlct_step(t1Mode, t1CountLow, t1CountHigh);
	assign t0hNext = {1'b0, t0CountHigh} + 9'h001;
	assign t0Ovf = t0Step & t0Next[16];
	assign t1Ovf = t1Step & t1Next[16];
	assign t0hOvf = t0hStep & t0hNext[8];

	// ------------------------------------------------------------
	// count registers; software write wins over a step
	// ------------------------------------------------------------
	// two bytes per timer, written separately
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			t0CountLow <= DLCT_COUNT_RST;
			t0CountHigh <= DLCT_COUNT_RST;
		end else begin
			if (t0LowWrite) begin
				t0CountLow <= writeData;
			end else if (t0Step) begin
				t0CountLow <= t0Next[7:0];
			end
			// high half counts separately when split
			if (t0HighWrite) begin
				t0CountHigh <= writeData;
			end else if (t0hStep) begin
				t0CountHigh <= t0hNext[7:0];
			end else if (t0Step && !split) begin
				t0CountHigh <= t0Next[15:8];
			end
		end
	end

	// timer 1 uses the same step logic
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			t1CountLow <= DLCT_COUNT_RST;
			t1CountHigh <= DLCT_COUNT_RST;
		end else begin
			if (t1LowWrite) begin
				t1CountLow <= writeData;
			end else if (t1Step) begin
				t1CountLow <= t1Next[7:0];
			end
			if (t1HighWrite) begin
				t1CountHigh <= writeData;
			end else if (t1Step) begin
				t1CountHigh <= t1Next[15:8];
			end
		end
	end

	// ------------------------------------------------------------
	// overflow flags, pulses and interrupts
	// ------------------------------------------------------------
	logic t1FlagSet;
	// timer 1 overflow never flags while split
	assign t1FlagSet = split ? t0hOvf : t1Ovf;

	// set wins over software clear or acknowledge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			t0OverflowFlag <= 1'b0;
			t1OverflowFlag <= 1'b0;
		end else begin
			if (t0Ovf) begin
				t0OverflowFlag <= 1'b1;
			end else if (t0FlagClear || t0IrqAck) begin
				t0OverflowFlag <= 1'b0;
			end
			if (t1FlagSet) begin
				t1OverflowFlag <= 1'b1;
			end else if (t1FlagClear || t1IrqAck) begin
				t1OverflowFlag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			t0OverflowPulse <= 1'b0;
			t1OverflowPulse <= 1'b0;
		end else begin
			t0OverflowPulse <= t0Ovf;
			t1OverflowPulse <= t1Ovf;
		end
	end

	// interrupt gated by its own enable
	assign t0Irq = t0OverflowFlag & t0IrqEnable;
	assign t1Irq = t1OverflowFlag & t1IrqEnable;
endmodule : dlct_timers

//--- verif/dlct_timers_sva.sv
// assertions on the dlct_timers ports, timer 0 side
// bound into every dlct_timers instance; one clock domain
`timescale 1ns/10ps
module dlct_timers_sva import dlct_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire dlct_pkg::dlct_mode_t t0Mode,
	input wire logic t0ClockSelect,
	input wire logic t0CounterMode,
	input wire logic t0Run,
	input wire logic t0GateEnable,
	input wire logic t0IrqEnable,
	input wire logic t0LowWrite,
	input wire logic t0HighWrite,
	input wire logic t0FlagClear,
	input wire logic t0IrqAck,
	input wire logic [7:0] t0CountLow,
	input wire logic [7:0] t0CountHigh,
	input wire logic t0OverflowFlag,
	input wire logic t0Irq,
	input wire logic t0OverflowPulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// ungated sysclk step with no byte write pending
	sequence sStep;
		t0Run && t0ClockSelect && !t0CounterMode && !t0GateEnable
			&& !t0LowWrite && !t0HighWrite;
	endsequence
	AST_IRQ_LEVEL: assert property (
		t0Irq == (t0OverflowFlag && t0IrqEnable)) else $error("irq level");
	AST_PULSE_AFTER: assert property (
		t0OverflowPulse |-> t0OverflowFlag) else $error("pulse");
	AST_STOPPED: assert property (
		!t0Run && !t0LowWrite |=> $stable(t0CountLow)) else $error("stop");
	AST_FLAG_HOLD: assert property (
		t0OverflowFlag && !t0FlagClear && !t0IrqAck |=> t0OverflowFlag)
		else $error("flag lost");
	AST_FLAG_CLEAR: assert property (
		t0FlagClear |=> !t0OverflowFlag || t0OverflowPulse)
		else $error("flag kept");
	AST_FLAG_PULSE: assert property (
		$rose(t0OverflowFlag) |-> t0OverflowPulse) else $error("no pulse");
	AST_WRAP16: assert property (
		sStep ##0 (t0Mode == DLCT_MODE16 && t0CountLow == 8'hFF
		&& t0CountHigh == 8'hFF) |=> t0OverflowFlag && t0CountLow == 8'h00
		&& t0CountHigh == 8'h00) else $error("wrap16");
	AST_RELOAD: assert property (
		sStep ##0 (t0Mode == DLCT_MODE8R && t0CountLow == 8'hFF)
		|=> t0CountLow == $past(t0CountHigh) && $stable(t0CountHigh))
		else $error("reload");
endmodule : dlct_timers_sva
bind dlct_timers dlct_timers_sva u_sva (.*);

//--- verif/dlct_pin_model.sv
// pin model: timer 0 event pin and a free-running ext clock
// assumes clk is the timers' system clock
`timescale 1ns/10ps
module dlct_pin_model (
	input wire logic clk,
	input wire logic go,
	output logic extClock = 1'h0,
	output logic eventPin = 1'h1
);
	logic divReg = 1'h0;
	logic [1:0] holdReg = 2'h0;
	// ext clock toggles every second clock
	always_ff @(posedge clk) begin
		divReg <= !divReg;
		if (divReg)
			extClock <= !extClock;
	end
	// each level held three clocks; idles high
	always_ff @(posedge clk) begin
		holdReg <= (go && holdReg != 2'h2) ? holdReg + 2'h1 : 2'h0;
		if (go && holdReg == 2'h2)
			eventPin <= !eventPin;
	end
endmodule : dlct_pin_model

//--- verif/dlct_timers_tb.sv
// self-checking bench for dlct_timers, timer 0 focus
// inputs change on falling clk; pin model drives event pin
`timescale 1ns/10ps
module dlct_timers_tb;
	import dlct_pkg::*;
	typedef struct {dlct_mode_t m; logic [7:0] h, l; int n;
		logic [7:0] eh, el, ef;} dlct_row_t;
	logic clk = 0, resetn = 0, go = 0, extClock, t0EventPin;
	dlct_mode_t t0Mode = DLCT_MODE16, t1Mode = DLCT_MODE16;
	logic [1:0] prescaleField = 2'h0;
	logic [7:0] writeData = 8'h00;
	logic t0ClockSelect = 1, t1ClockSelect = 1, t0CounterMode = 0;
	logic t1CounterMode = 0, t0Run = 0, t1Run = 0, t0GateEnable = 0;
	logic t1GateEnable = 0, t0GatePolarity = 0, t1GatePolarity = 0;
	logic t0IrqEnable = 0, t1IrqEnable = 0, t1EventPin = 1;
	logic t0GateInput = 0, t1GateInput = 0, t0LowWrite = 0;
	logic t0HighWrite = 0, t1LowWrite = 0, t1HighWrite = 0;
	logic t0FlagClear = 0, t1FlagClear = 0, t0IrqAck = 0, t1IrqAck = 0;
	logic [7:0] t0CountLow, t0CountHigh, t1CountLow, t1CountHigh;
	logic t0OverflowFlag, t1OverflowFlag, t0Irq, t1Irq;
	logic t0OverflowPulse, t1OverflowPulse;
	int bad_count = 0, check_count = 0;
	int psN[4] = '{48, 40, 96, 64};
	logic [7:0] psE[4] = '{8'h04, 8'h0A, 8'h02, 8'h02};
	dlct_row_t rows[5] = '{
		'{DLCT_MODE13, 8'hFF, 8'hFF, 1, 8'h00, 8'hE0, 8'h01},
		'{DLCT_MODE13, 8'h00, 8'h1E, 2, 8'h01, 8'h00, 8'h00},
		'{DLCT_MODE16, 8'hFF, 8'hFF, 1, 8'h00, 8'h00, 8'h01},
		'{DLCT_MODE16, 8'h12, 8'h34, 5, 8'h12, 8'h39, 8'h00},
		'{DLCT_MODE8R, 8'h80, 8'hFF, 1, 8'h80, 8'h80, 8'h01}};
	dlct_timers u_dut (.*);
	dlct_pin_model u_pins (.clk(clk), .go(go), .extClock(extClock),
		.eventPin(t0EventPin));
	always #5 clk = ~clk;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	// load high then low byte, clearing both flags on the way
	task automatic wr(input logic [7:0] h, input logic [7:0] l);
		@(negedge clk) {t0HighWrite, writeData} = {1'h1, h};
		@(negedge clk) {t0HighWrite, t0LowWrite, writeData} = {2'h1, l};
		@(negedge clk) {t0LowWrite, t0FlagClear, t1FlagClear} = 3'h3;
		@(negedge clk) {t0FlagClear, t1FlagClear} = 2'h0;
	endtask : wr
	// run held for exactly n rising edges
	task automatic run(input int n);
		@(negedge clk) t0Run = 1'h1;
		repeat (n) @(negedge clk);
		t0Run = 1'h0;
	endtask : run
	// hang guard well above the cycle budget
	initial begin
		#500us;
		bad_count++;
		test_done();
	end
	initial begin
		repeat (5) @(negedge clk);
		resetn = 1'h1;
		chk(t0CountLow | t0CountHigh | t1CountLow, 8'h00);
		foreach (rows[i]) begin
			t0Mode = rows[i].m;
			wr(rows[i].h, rows[i].l);
			run(rows[i].n);
			chk(t0CountHigh, rows[i].eh);
			chk(t0CountLow, rows[i].el);
			chk({7'h0, t0OverflowFlag}, rows[i].ef);
		end
		$display("mode rows done");
		t0Mode = DLCT_MODE16;
		t0ClockSelect = 1'h0;
		foreach (psN[i]) begin
			prescaleField = 2'(i);
			wr(8'h00, 8'h00);
			run(psN[i]);
			chk(t0CountLow, psE[i]);
		end
		$display("prescaler done");
		t0CounterMode = 1'h1;
		wr(8'h00, 8'h00);
		t0Run = 1'h1;
		go = 1'h1;
		repeat (30) @(negedge clk);
		go = 1'h0;
		repeat (4) @(negedge clk);
		t0Run = 1'h0;
		chk(t0CountLow, 8'h05);
		{t0CounterMode, t0ClockSelect} = 2'h1;
		{t0GateEnable, t0GatePolarity} = 2'h3;
		wr(8'h00, 8'h00);
		run(10);
		chk(t0CountLow, 8'h00);
		t0GatePolarity = 1'h0;
		run(10);
		chk(t0CountLow, 8'h0A);
		t0GateEnable = 1'h0;
		$display("event and gate done");
		wr(8'hFF, 8'hFF);
		t0IrqEnable = 1'h1;
		run(1);
		chk({7'h0, t0Irq}, 8'h01);
		@(negedge clk) t0IrqAck = 1'h1;
		@(negedge clk) t0IrqAck = 1'h0;
		chk({7'h0, t0OverflowFlag}, 8'h00);
		{t0Mode, t1Mode} = {DLCT_MODESPLIT, DLCT_MODESPLIT};
		wr(8'hFF, 8'h10);
		@(negedge clk) t1Run = 1'h1;
		@(negedge clk) t1Run = 1'h0;
		chk(t0CountHigh, 8'h00);
		chk({7'h0, t1OverflowFlag}, 8'h01);
		chk(t0CountLow, 8'h10);
		chk(t1CountLow | t1CountHigh, 8'h00);
		$display("irq and split done");
		// timer 1 bytes loaded while halted by its split mode
		@(negedge clk) {t1HighWrite, writeData} = {1'h1, 8'hFF};
		@(negedge clk) {t1HighWrite, t1LowWrite, t1FlagClear} = 3'h3;
		@(negedge clk) {t1LowWrite, t1FlagClear} = 2'h0;
		t1Mode = DLCT_MODE8R;
		t1IrqEnable = 1'h1;
		// split: timer 1 pulses on internal clock but never flags
		@(negedge clk) chk({6'h0, t1OverflowPulse, t1OverflowFlag}, 8'h02);
		t0Mode = DLCT_MODE16;
		t1Run = 1'h1;
		@(negedge clk) t1Run = 1'h0;
		chk({6'h0, t1Irq, t1OverflowPulse}, 8'h03);
		$display("timer 1 done");
		// reset again in mid-run; nothing may count after release
		@(negedge clk) resetn = 1'h0;
		@(negedge clk) chk({6'h0, t1OverflowFlag, t1Irq} | t1CountLow, 8'h00);
		resetn = 1'h1;
		repeat (2) @(negedge clk);
		chk(t1CountLow | t1CountHigh | t0CountLow, 8'h00);
		$display("reset done");
		test_done();
	end
endmodule : dlct_timers_tb
